// file: core/lsr_defines.svh
// Constants for the light sensor readout: bus address, command codes,
// result field layout, reset values and timing figures.
// Assumes a 250 MHz core clock; included by its bare name.
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH

// Core clock rate in MHz, used to turn times into cycle counts.
`define LSR_CLK_MHZ          250
// Integration time per channel in standard range, in ms.
`define LSR_STD_INTEG_MS     400
// Extended range shortens integration by this factor.
`define LSR_EXT_DIVISOR      5
// Least bus-low time that counts as a stuck bus, in ms.
`define LSR_TIMEOUT_MS       25
// Counter widths that hold the cycle counts above.
`define LSR_INTEG_W          27
`define LSR_TIMEOUT_W        23

// Fixed seven-bit slave address, binary 0111001.
`define LSR_SLAVE_ADDR       7'h39

// Command byte codes.
`define LSR_CMD_POWER_DOWN   8'h00
`define LSR_CMD_POWER_UP     8'h03
`define LSR_CMD_EXT_RANGE    8'h1d
`define LSR_CMD_STD_RANGE    8'h18
`define LSR_CMD_READ_CH0     8'h43
`define LSR_CMD_READ_CH1     8'h83
`define LSR_CMD_RESET        8'h00

// Result register layout.
`define LSR_VALID_BIT        7
`define LSR_SEG_MSB          6
`define LSR_SEG_LSB          4
`define LSR_STEP_MSB         3
`define LSR_STEP_LSB         0
`define LSR_RESULT_RESET     8'h00
// Linear counts at or above this value saturate to the overflow code.
`define LSR_OVERFLOW_COUNT   12'hfaf
`define LSR_OVERFLOW_CODE    7'h7f

`endif

// file: core/lsr_pkg.sv
// Types shared by the light sensor readout.
// Assumes lsr_defines.svh supplies every numeric constant.
package lsr_pkg;

  // Serial slave states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_AACK  = 7'h04,
    ST_WBYTE = 7'h08,
    ST_WACK  = 7'h10,
    ST_RBYTE = 7'h20,
    ST_RACK  = 7'h40
  } lsr_bus_state_e;

  // Source of the byte returned by a receive byte.
  typedef enum logic [2:0] {
    SEL_CMD = 3'h1,
    SEL_CH0 = 3'h2,
    SEL_CH1 = 3'h4
  } lsr_read_sel_e;

endpackage

// file: core/lsr_readout.sv
// Digital core of a two-channel ambient light sensor with a two-wire
// serial slave (send byte / receive byte).
// Assumes the analog front end presents a linear count on clk and that
// the bus pins are asynchronous; the data pin is open drain.
//
// Function
// - Integrate channel 0, then channel 1, alternately.
// - Results reach result registers via double buffer.
// - Next conversion starts automatically after transfer.
// - Standard range integrates 400 ms per channel.
// - Extended range: one fifth time and responsivity.
// - Eight-bit command register, writable and readable.
// - Two read-only per-channel result registers.
// - Answer only slave address 0111001.
// - Send byte stores byte in command register.
// - Receive byte returns command or selected result.
// - 0x00 powers down; 0x03 powers up, reads command.
// - 0x43 selects channel 0, 0x83 channel 1.
// - 0x1D extended range; 0x18 standard range.
// - Command register loads 0x00 at power-up.
// - Range persists until power-down or new range.
// - After 0x03, receive byte returns 0x03.
// - Valid bit 7, segment 6:4, step 3:0.
// - Valid set only after result since power-up.
// - All zeros below limit, all ones overflow.
// - Code is eight segments of sixteen steps.
// - Interface works with bus revisions 1.1, 2.0.
// - Repeated reads return same value until update.
// - Bus held low 25-35 ms aborts transaction.
`timescale 1ns/1ps
`include "lsr_defines.svh"

module lsr_readout
  import lsr_pkg::*;
#(
  parameter int unsigned INTEG_STD_CYC =
    `LSR_STD_INTEG_MS * `LSR_CLK_MHZ * 1000,
  parameter int unsigned INTEG_EXT_CYC = INTEG_STD_CYC / `LSR_EXT_DIVISOR,
  parameter int unsigned TIMEOUT_CYC   =
    `LSR_TIMEOUT_MS * `LSR_CLK_MHZ * 1000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        smbClkIn,
  input  wire logic        smbDataIn,
  output logic             smbDataOut,
  output logic             smbDataOe,
  input  wire logic [11:0] adcCount,
  output logic             integrating,
  output logic             integChannel,
  output logic             extendedRange
);

  // Linear count to segment/step code; saturates to the overflow code.
  function automatic logic [6:0] compand(input logic [11:0] cnt);
    logic [11:0] base;
    logic [11:0] diff;
    logic [2:0]  seg;
    logic [3:0]  stp;
    base = 12'h000;
    diff = 12'h000;
    seg  = 3'h0;
    stp  = 4'h0;
    for (int c = 0; c < 8; c++) begin
      case (c)
        0:       base = 12'h000;
        1:       base = 12'h010;
        2:       base = 12'h031;
        3:       base = 12'h073;
        4:       base = 12'h0f7;
        5:       base = 12'h1ff;
        6:       base = 12'h40f;
        default: base = 12'h82f;
      endcase
      if (cnt >= base) begin
        seg  = 3'(c);
        diff = 12'(cnt - base);
        stp  = 4'(diff >> c);
      end
    end
    if (cnt >= `LSR_OVERFLOW_COUNT) begin
      compand = `LSR_OVERFLOW_CODE;
    end else begin
      compand = {seg, stp};
    end
  endfunction

  localparam logic [`LSR_INTEG_W-1:0]   STD_LAST =
    `LSR_INTEG_W'(INTEG_STD_CYC - 1);
  localparam logic [`LSR_INTEG_W-1:0]   EXT_LAST =
    `LSR_INTEG_W'(INTEG_EXT_CYC - 1);
  localparam logic [`LSR_TIMEOUT_W-1:0] TO_LAST  =
    `LSR_TIMEOUT_W'(TIMEOUT_CYC - 1);

  logic                      sclMeta;
  logic                      sclSync;
  logic                      sclPrev;
  logic                      sdaMeta;
  logic                      sdaSync;
  logic                      sdaPrev;
  logic                      sclRise;
  logic                      sclFall;
  logic                      busStart;
  logic                      busStop;
  lsr_bus_state_e            state;
  logic [3:0]                bitCnt;
  logic [7:0]                shiftReg;
  logic                      readDir;
  logic                      cmdWrite;
  logic [7:0]                cmdByte;
  logic [`LSR_TIMEOUT_W-1:0] lowCnt;
  logic                      timedOut;
  logic [7:0]                controlCommand;
  lsr_read_sel_e             readSel;
  logic                      converterEnable;
  logic                      enablePrev;
  logic [`LSR_INTEG_W-1:0]   integCnt;
  logic [6:0]                stageCode;
  logic                      stageChan;
  logic                      stagePending;
  logic                      readBusy;
  logic [7:0]                channel0Result;
  logic [7:0]                channel1Result;
  logic [7:0]                readByte;

  // Two-stage synchronisers; only the second stage and later are read.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= smbClkIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= smbDataIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  // Bus events; start and stop need the clock line stable high.
  assign sclRise  = sclSync & ~sclPrev;
  assign sclFall  = ~sclSync & sclPrev;
  assign busStart = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign busStop  = sclSync & sclPrev & ~sdaPrev & sdaSync;

  // Stuck-bus watchdog: either line low for the timeout aborts a transfer.
  always_ff @(posedge clk) begin
    if (rst) begin
      lowCnt   <= '0;
      timedOut <= 1'b0;
    end else if (sclSync & sdaSync) begin
      lowCnt   <= '0;
      timedOut <= 1'b0;
    end else if (lowCnt == TO_LAST) begin
      timedOut <= 1'b1;
    end else begin
      lowCnt   <= lowCnt + 1'b1;
      timedOut <= 1'b0;
    end
  end

  // Byte handed back on a receive byte, chosen by the last select.
  always_comb begin
    case (readSel)
      SEL_CH0: readByte = channel0Result;
      SEL_CH1: readByte = channel1Result;
      default: readByte = controlCommand;
    endcase
  end

  // Serial slave. Data changes on clock falls, sampled on rises, so the
  // host sees hold of over a clock phase and setup of a phase less the sync delay.
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= ST_IDLE;
      bitCnt     <= 4'h0;
      shiftReg   <= 8'h00;
      readDir    <= 1'b0;
      smbDataOe  <= 1'b0;
      smbDataOut <= 1'b0;
      cmdWrite   <= 1'b0;
      cmdByte    <= 8'h00;
    end else begin
      cmdWrite <= 1'b0;
      if (timedOut && state != ST_IDLE) begin
        state     <= ST_IDLE;
        smbDataOe <= 1'b0;
      end else if (busStart) begin
        state     <= ST_ADDR;
        bitCnt    <= 4'h0;
        smbDataOe <= 1'b0;
      end else if (busStop) begin
        state     <= ST_IDLE;
        smbDataOe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaSync};
              bitCnt   <= bitCnt + 1'b1;
            end else if (sclFall && bitCnt == 4'h8) begin
              if (shiftReg[7:1] == `LSR_SLAVE_ADDR) begin
                smbDataOe <= 1'b1;
                readDir   <= shiftReg[0];
                state     <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (readDir) begin
                shiftReg  <= readByte;
                smbDataOe <= ~readByte[7];
                state     <= ST_RBYTE;
              end else begin
                smbDataOe <= 1'b0;
                state     <= ST_WBYTE;
              end
            end
          end
          ST_WBYTE: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaSync};
              bitCnt   <= bitCnt + 1'b1;
            end else if (sclFall && bitCnt == 4'h8) begin
              smbDataOe <= 1'b1;
              cmdWrite  <= 1'b1;
              cmdByte   <= shiftReg;
              state     <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (sclFall) begin
              smbDataOe <= 1'b0;
              state     <= ST_IDLE;
            end
          end
          ST_RBYTE: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 1'b1;
            end else if (sclFall) begin
              if (bitCnt == 4'h8) begin
                smbDataOe <= 1'b0;
                state     <= ST_RACK;
              end else begin
                shiftReg  <= {shiftReg[6:0], 1'b0};
                smbDataOe <= ~shiftReg[6];
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              // A host acknowledge asks for the byte again.
              state <= sdaSync ? ST_IDLE : ST_AACK;
            end
          end
          default: begin
            smbDataOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Command register and what it steers: power, range, read source.
  always_ff @(posedge clk) begin
    if (rst) begin
      controlCommand  <= `LSR_CMD_RESET;
      readSel         <= SEL_CMD;
      converterEnable <= 1'b0;
      extendedRange   <= 1'b0;
    end else if (cmdWrite) begin
      controlCommand <= cmdByte;
      case (cmdByte)
        `LSR_CMD_POWER_DOWN: begin
          converterEnable <= 1'b0;
          extendedRange   <= 1'b0;
        end
        `LSR_CMD_POWER_UP: begin
          converterEnable <= 1'b1;
          readSel         <= SEL_CMD;
        end
        `LSR_CMD_READ_CH0: begin
          converterEnable <= 1'b1;
          readSel         <= SEL_CH0;
        end
        `LSR_CMD_READ_CH1: begin
          converterEnable <= 1'b1;
          readSel         <= SEL_CH1;
        end
        `LSR_CMD_EXT_RANGE: extendedRange <= 1'b1;
        `LSR_CMD_STD_RANGE: extendedRange <= 1'b0;
        default: begin
          readSel <= SEL_CMD;
        end
      endcase
    end
  end

  // Conversion sequencer: fixed integration windows, channel 0 first.
  // The front end scales its responsivity from extendedRange.
  always_ff @(posedge clk) begin
    if (rst) begin
      enablePrev   <= 1'b0;
      integCnt     <= '0;
      integChannel <= 1'b0;
      integrating  <= 1'b0;
      stageCode    <= 7'h00;
      stageChan    <= 1'b0;
      stagePending <= 1'b0;
    end else begin
      enablePrev  <= converterEnable;
      integrating <= converterEnable;
      if (!converterEnable || !enablePrev) begin
        integCnt     <= '0;
        integChannel <= 1'b0;
        stagePending <= 1'b0;
      end else begin
        if ((extendedRange && integCnt >= EXT_LAST) ||
            (!extendedRange && integCnt == STD_LAST)) begin
          stageCode    <= compand(adcCount);
          stageChan    <= integChannel;
          stagePending <= 1'b1;
          integChannel <= ~integChannel;
          integCnt     <= '0;
        end else begin
          integCnt <= integCnt + 1'b1;
          if (!readBusy) begin
            stagePending <= 1'b0;
          end
        end
      end
    end
  end

  // A result never moves while a read byte is being shifted out.
  assign readBusy = (state == ST_AACK) | (state == ST_RBYTE) | (state == ST_RACK);

  // Result registers, loaded from the staging copy between reads.
  always_ff @(posedge clk) begin
    if (rst) begin
      channel0Result <= `LSR_RESULT_RESET;
      channel1Result <= `LSR_RESULT_RESET;
    end else if (converterEnable && !enablePrev) begin
      channel0Result[`LSR_VALID_BIT] <= 1'b0;
      channel1Result[`LSR_VALID_BIT] <= 1'b0;
    end else if (stagePending && !readBusy) begin
      if (stageChan) begin
        channel1Result <= {1'b1, stageCode};
      end else begin
        channel0Result <= {1'b1, stageCode};
      end
    end
  end

endmodule // lsr_readout

// file: test/lsr_readout_chk.sv
// Port assertions for the light sensor readout.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps

module lsr_readout_chk #(
  parameter int unsigned INTEG_STD_CYC = 200,
  parameter int unsigned INTEG_EXT_CYC = 40,
  parameter int unsigned TIMEOUT_CYC   = 500
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        smbClkIn,
  input wire logic        smbDataIn,
  input wire logic        smbDataOut,
  input wire logic        smbDataOe,
  input wire logic [11:0] adcCount,
  input wire logic        integrating,
  input wire logic        integChannel,
  input wire logic        extendedRange
);
  logic        prevChan;
  logic        prevExt;
  logic        mixed;
  logic [31:0] winCnt;
  logic [31:0] lowCnt;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles since the current integration window opened.
  always_ff @(posedge clk) begin
    prevChan <= integChannel;
    if (rst || !integrating || integChannel != prevChan) begin
      winCnt <= 32'h0;
    end else begin
      winCnt <= winCnt + 32'h1;
    end
  end

  // A range change inside a window makes its length undefined, so skip it.
  always_ff @(posedge clk) begin
    prevExt <= extendedRange;
    if (rst) begin
      mixed <= 1'b0;
    end else if (extendedRange != prevExt) begin
      mixed <= 1'b1;
    end else if (!integrating || integChannel != prevChan) begin
      mixed <= 1'b0;
    end
  end

  // Cycles the bus clock has been held low.
  always_ff @(posedge clk) begin
    if (rst || smbClkIn) begin
      lowCnt <= 32'h0;
    end else begin
      lowCnt <= lowCnt + 32'h1;
    end
  end

  a_data_out_low: assert property (smbDataOut == 1'b0)
    else $error("data pin output value not low");
  a_reset_quiet: assert property ($fell(rst) |->
    !smbDataOe && !integrating && !extendedRange && !integChannel)
    else $error("outputs not idle after reset");
  a_first_channel: assert property ($rose(integrating) |-> !integChannel)
    else $error("conversion did not start on channel 0");
  a_toggle_when_on: assert property ($changed(integChannel) |->
    integrating || $past(integrating))
    else $error("channel changed while converter off");
  a_std_window: assert property ($rose(integChannel) && !mixed && !extendedRange
    |-> winCnt + 3 >= INTEG_STD_CYC && winCnt <= INTEG_STD_CYC + 3)
    else $error("standard window length wrong");
  a_ext_window: assert property ($rose(integChannel) && !mixed && extendedRange
    |-> winCnt + 3 >= INTEG_EXT_CYC && winCnt <= INTEG_EXT_CYC + 3)
    else $error("extended window length wrong");
  a_window_bound: assert property (integrating |-> winCnt <= INTEG_STD_CYC + 3)
    else $error("next conversion did not start");
  a_timeout_release: assert property (lowCnt > TIMEOUT_CYC + 8 |-> !smbDataOe)
    else $error("data still driven on stuck bus");
  a_oe_clk_low: assert property ($changed(smbDataOe) |->
    !$past(smbClkIn, 3) || !$past(smbClkIn, 4))
    else $error("data changed while bus clock high");
endmodule // lsr_readout_chk

bind lsr_readout lsr_readout_chk #(
  .INTEG_STD_CYC(INTEG_STD_CYC),
  .INTEG_EXT_CYC(INTEG_EXT_CYC),
  .TIMEOUT_CYC  (TIMEOUT_CYC)
) u_chk (
  .clk          (clk),
  .rst          (rst),
  .smbClkIn     (smbClkIn),
  .smbDataIn    (smbDataIn),
  .smbDataOut   (smbDataOut),
  .smbDataOe    (smbDataOe),
  .adcCount     (adcCount),
  .integrating  (integrating),
  .integChannel (integChannel),
  .extendedRange(extendedRange)
);

// file: test/lsr_readout_tb_top.sv
// Self-checking bench for the light sensor readout with a bus host model.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`include "lsr_defines.svh"

module lsr_readout_tb_top;
  // Short counts keep the run small; expectations use the same values.
  localparam int unsigned STD = 200;
  localparam int unsigned TMO = 500;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] adc = 12'h000;
  logic        scl;
  logic        hostLow;
  wire         sda;
  logic        dataOut;
  logic        dataOe;
  logic        integ;
  logic        chan;
  logic        ext;
  logic [7:0]  rd;
  logic        ack;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  // Open-drain wire with pull-up: low if either party pulls.
  assign sda = !(hostLow || dataOe);

  lsr_readout #(
    .INTEG_STD_CYC(STD),
    .INTEG_EXT_CYC(STD / 5),
    .TIMEOUT_CYC  (TMO)
  ) u_dut (
    .clk          (clk),
    .rst          (rst),
    .smbClkIn     (scl),
    .smbDataIn    (sda),
    .smbDataOut   (dataOut),
    .smbDataOe    (dataOe),
    .adcCount     (adc),
    .integrating  (integ),
    .integChannel (chan),
    .extendedRange(ext)
  );

  lsr_smb_host u_host (
    .scl   (scl),
    .sdaLow(hostLow),
    .sda   (sda)
  );

  task automatic conclude;
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Every stimulus change lands 1 ns after a rising edge.
  task automatic edge1;
    @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [7:0] c);
    edge1();
    u_host.send(`LSR_SLAVE_ADDR, c, ack);
  endtask

  task automatic recv;
    edge1();
    u_host.recv(rd);
  endtask

  // Bounded wait for the converter to reach a channel.
  task automatic waitChan(input logic v);
    int n;
    n = 0;
    while (chan !== v && n < 2000) begin
      edge1();
      n++;
    end
    chk(chan, v);
  endtask

  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) edge1();
    recv();
    chk(rd, 8'h00);
    edge1();
    u_host.send(7'h3a, 8'h03, ack);
    chk(ack, 1'b0);
    chk(integ, 1'b0);
    send(8'h03);
    chk(ack, 1'b1);
    recv();
    chk(rd, 8'h03);
    chk(integ, 1'b1);
    chk(chan, 1'b0);
    send(8'h00);
    chk(integ, 1'b0);
    // Count 100 falls in segment 2 (base 49, step 4), step 12.
    adc = 12'h064;
    send(8'h43);
    recv();
    chk(rd, 8'h00);
    waitChan(1'b1);
    recv();
    chk(rd, 8'hac);
    // Segment 2 step 12 decodes to 49 + 12 * 4 = 97, just below the count sent.
    chk(8'(u_host.decode(rd[6:0])), 8'h61);
    recv();
    chk(rd, 8'hac);
    adc = 12'hfff;
    waitChan(1'b1);
    waitChan(1'b0);
    adc = 12'h000;
    send(8'h83);
    recv();
    chk(rd, 8'hff);
    waitChan(1'b1);
    send(8'h43);
    recv();
    chk(rd, 8'h80);
    // An unlisted byte is kept and turns reads back to the command register.
    send(8'h5a);
    recv();
    chk(rd, 8'h5a);
    send(8'h1d);
    chk(ext, 1'b1);
    send(8'h43);
    chk(ext, 1'b1);
    waitChan(1'b1);
    waitChan(1'b0);
    send(8'h18);
    chk(ext, 1'b0);
    send(8'h1d);
    send(8'h00);
    chk(ext, 1'b0);
    chk(integ, 1'b0);
    // Park the clock low while the device drives a data bit.
    send(8'h03);
    edge1();
    u_host.start();
    u_host.putByte({`LSR_SLAVE_ADDR, 1'b1}, ack);
    u_host.hold();
    repeat (TMO + 20) edge1();
    chk(dataOe, 1'b0);
    u_host.stop();
    recv();
    chk(rd, 8'h03);
    conclude();
  end
endmodule // lsr_readout_tb_top

// file: test/lsr_smb_host.sv
// Behavioural bus host for the sensor: send byte and receive byte.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`include "lsr_defines.svh"

module lsr_smb_host (
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sda
);
  // The bus clock idles high and only runs inside frames.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // One 32 ns bit: data moves mid-low, the line is read mid-high.
  task automatic bitIo(input logic b, output logic r);
    scl = 1'b0;
    #8 sdaLow = !b;
    #8 scl = 1'b1;
    #8 r = sda;
    #8;
  endtask

  // Start: data falls while the clock is high.
  task automatic start;
    sdaLow = 1'b1;
    #16;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop;
    scl = 1'b0;
    #8 sdaLow = 1'b1;
    #8 scl = 1'b1;
    #16 sdaLow = 1'b0;
    #16;
  endtask

  // Parks the clock low so the device's stuck-bus guard can act.
  task automatic hold;
    scl = 1'b0;
  endtask

  // Eight bits out, most significant first, then the device's answer.
  task automatic putByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], r);
    end
    bitIo(1'b1, r);
    ack = !r;
  endtask

  // Eight bits in, then a refusal so the device lets go.
  task automatic getByte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(1'b1, r);
  endtask

  // Send byte; the command is skipped if the address is refused.
  task automatic send(input logic [6:0] a, input logic [7:0] c, output logic ack);
    start();
    putByte({a, 1'b0}, ack);
    if (ack) begin
      putByte(c, ack);
    end
    stop();
  endtask

  // Receive byte from the fixed address.
  task automatic recv(output logic [7:0] d);
    logic a;
    start();
    putByte({`LSR_SLAVE_ADDR, 1'b1}, a);
    getByte(d);
    stop();
  endtask

  // Linear count that a result code stands for: the segment's base count plus
  // the step number times the segment's step size. The base is 16.5 times one
  // less than the step size, done as 33/2 so that the fraction truncates.
  function automatic logic [11:0] decode(input logic [6:0] code);
    logic [11:0] span;
    span   = 12'h001 << code[6:4];
    decode = 12'((32'h21 * (span - 12'h001)) >> 1) + 12'(code[3:0]) * span;
  endfunction
endmodule // lsr_smb_host
